/* File: shared/cies_consts.vh */
/*
 * constants for the control-transfer instruction executor: opcodes,
 * timing in states, flag positions in the program status word.
 * assumes inclusion by bare name from the design file.
 */
`ifndef CIES_CONSTS_VH
`define CIES_CONSTS_VH
// opcode patterns
`define CIES_OP_NOP          8'h00
`define CIES_OP_DBNZ_DIR     8'hd5
`define CIES_OP_ABSOLUTE_CALL_OP_LOW5   5'h11
// instruction lengths in bytes
`define CIES_LEN_NOP         3'h1
`define CIES_LEN_DBNZ        3'h3
`define CIES_LEN_ABSOLUTE_CALL_OP       3'h2
// execution time in states (one state per enable pulse)
`define CIES_STATES_CYCLE    4'h6
`define CIES_STATES_NOP      4'h6
`define CIES_STATES_LONG     4'hc
// core clocks per state
`define CIES_CLKS_PER_STATE  2'h2
// flag bit positions in program status word
`define CIES_BIT_CARRY       7
`define CIES_BIT_AUXCARRY    6
`define CIES_BIT_OVERFLOW    2
// reset values
`define CIES_RST_SP          8'h07
`define CIES_RST_PC          16'h0000
`define CIES_RST_PSW         8'h00
`endif

/* File: verilog/cies_exec.v */
/*
 * executor for a subset of control-transfer instructions: no-operation,
 * direct-byte decrement and branch if nonzero, absolute call in a 2 KB page.
 * assumes program memory and data ram answer combinationally on the
 * same cycle as the address they are given.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cies_consts.vh"
module cies_exec
(
	input  wire        i_clk,
	input  wire        i_srst,
	input  wire [7:0]  i_code_data,
	input  wire [7:0]  i_ram_rdata,
	input  wire [7:0]  i_psw_in,
	output reg  [15:0] o_code_addr,
	output reg  [7:0]  o_ram_addr,
	output reg  [7:0]  o_ram_wdata,
	output reg         o_ram_we,
	output reg  [7:0]  o_sp,
	output reg  [7:0]  o_psw,
	output reg  [15:0] o_pc,
	output reg         o_illegal,
	output reg         o_instr_done
);
	localparam [2:0] ST_FETCH  = 3'h0;
	localparam [2:0] ST_OPND1  = 3'h1;
	localparam [2:0] ST_OPND2  = 3'h2;
	localparam [2:0] ST_EXEC   = 3'h3;
	localparam [2:0] ST_PUSH_H = 3'h4;
	localparam [2:0] ST_WAIT   = 3'h5;

	reg [2:0]  state_r;
	reg [0:0]  div_r;
	reg [3:0]  states_r;
	reg [3:0]  need_r;
	reg [7:0]  op_r;
	reg [7:0]  b2_r;
	reg [7:0]  b3_r;
	reg [15:0] ret_r;
	wire       state_tick;

	// flag effect codes, one two-bit code per flag
	localparam [1:0] FX_CLEAR  = 2'h0; // forced to zero
	localparam [1:0] FX_SET    = 2'h1; // forced to one
	localparam [1:0] FX_KEEP   = 2'h2; // unmodified or indeterminate
	localparam [1:0] FX_RESULT = 2'h3; // written from the result

	wire [5:0] fx_codes;  // carry, aux carry, overflow, two bits each
	wire [2:0] flag_res;  // flag values an operation would produce
	wire [2:0] flag_old;  // flags as they stand before execution
	reg  [2:0] flag_new;
	reg  [7:0] psw_nxt;
	integer    fi;

	//////////////////////////////////////////////////////////////////
	// state-time enable from the core clock
	always @(posedge i_clk)
	begin
		if (i_srst)
			div_r <= 1'b0;
		else if (div_r == (`CIES_CLKS_PER_STATE - 2'h1))
			div_r <= 1'b0;
		else
			div_r <= div_r + 1'b1;
	end
	assign state_tick = (div_r == (`CIES_CLKS_PER_STATE - 2'h1));

	//////////////////////////////////////////////////////////////////
	// flag effects; every op of this subset leaves the flags alone
	assign fx_codes = {FX_KEEP, FX_KEEP, FX_KEEP};
	assign flag_res = 3'h0; // no op here produces an arithmetic result
	assign flag_old = {i_psw_in[`CIES_BIT_CARRY], i_psw_in[`CIES_BIT_AUXCARRY],
		i_psw_in[`CIES_BIT_OVERFLOW]};

	// apply one effect code to each flag
	always @*
	begin
		flag_new = flag_old;
		for (fi = 0; fi < 3; fi = fi + 1)
		begin
			case (fx_codes[2*fi +: 2])
			FX_RESULT: flag_new[fi] = flag_res[fi];
			FX_SET:    flag_new[fi] = 1'b1;
			FX_CLEAR:  flag_new[fi] = 1'b0;
			default:   flag_new[fi] = flag_old[fi]; // kept value
			endcase
		end
	end

	// rebuild the status word with the updated flags in place
	always @*
	begin
		psw_nxt                     = i_psw_in;
		psw_nxt[`CIES_BIT_CARRY]    = flag_new[2];
		psw_nxt[`CIES_BIT_AUXCARRY] = flag_new[1];
		psw_nxt[`CIES_BIT_OVERFLOW] = flag_new[0];
	end

	//////////////////////////////////////////////////////////////////
	// sequencer: fetch bytes, act, then pad to the instruction's states
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_r      <= ST_FETCH;
			states_r     <= 4'h0;
			need_r       <= 4'h0;
			op_r         <= 8'h00;
			b2_r         <= 8'h00;
			b3_r         <= 8'h00;
			ret_r        <= 16'h0000;
			o_pc         <= `CIES_RST_PC;
			o_code_addr  <= `CIES_RST_PC;
			o_sp         <= `CIES_RST_SP;
			o_psw        <= `CIES_RST_PSW;
			o_ram_addr   <= 8'h00;
			o_ram_wdata  <= 8'h00;
			o_ram_we     <= 1'b0;
			o_illegal    <= 1'b0;
			o_instr_done <= 1'b0;
		end
		else
		begin
			o_ram_we     <= 1'b0;
			o_instr_done <= 1'b0;
			if (state_tick)
			begin
				states_r <= states_r + 4'h1;
				case (state_r)
				ST_FETCH:
				begin
					op_r        <= i_code_data;
					o_psw       <= psw_nxt; // flag image before execution
					// count runs to the end of the next state, so the
					// last wait state ends exactly on the op's state count
					states_r    <= 4'h2;
					o_illegal   <= 1'b0;
					o_code_addr <= o_pc + 16'h0001;
					if (i_code_data == `CIES_OP_NOP)
					begin
						// only the pc moves
						o_pc    <= o_pc + {13'h0000, `CIES_LEN_NOP};
						need_r  <= `CIES_STATES_NOP;
						state_r <= ST_WAIT;
					end
					else if (i_code_data == `CIES_OP_DBNZ_DIR ||
						i_code_data[4:0] == `CIES_OP_ABSOLUTE_CALL_OP_LOW5)
					begin
						need_r  <= `CIES_STATES_LONG;
						state_r <= ST_OPND1;
					end
					else
					begin
						o_illegal <= 1'b1;
						o_pc      <= o_pc + 16'h0001;
						need_r    <= `CIES_STATES_CYCLE;
						state_r   <= ST_WAIT;
					end
				end
				ST_OPND1:
				begin
					b2_r        <= i_code_data;
					o_code_addr <= o_pc + 16'h0002;
					o_ram_addr  <= i_code_data; // direct_address_operand
					if (op_r == `CIES_OP_DBNZ_DIR)
						state_r <= ST_OPND2; // three bytes
					else
					begin
						// return address = pc + 2
						ret_r       <= o_pc + {13'h0000, `CIES_LEN_ABSOLUTE_CALL_OP};
						o_sp        <= o_sp + 8'h01; // increment before write
						o_ram_addr  <= o_sp + 8'h01;
						o_ram_wdata <= o_pc[7:0] + 8'h02; // low byte first
						o_ram_we    <= 1'b1;
						state_r     <= ST_PUSH_H;
					end
				end
				ST_OPND2:
				begin
					b3_r    <= i_code_data;
					state_r <= ST_EXEC;
				end
				ST_EXEC:
				begin
					// decrement stored byte; flags untouched
					o_ram_wdata <= i_ram_rdata - 8'h01;
					o_ram_we    <= 1'b1;
					if (i_ram_rdata != 8'h01)
						o_pc <= o_pc + {13'h0000, `CIES_LEN_DBNZ} + {{8{b3_r[7]}}, b3_r};
					else
						o_pc <= o_pc + {13'h0000, `CIES_LEN_DBNZ};
					state_r <= ST_WAIT;
				end
				ST_PUSH_H:
				begin
					o_sp        <= o_sp + 8'h01;
					o_ram_addr  <= o_sp + 8'h01;
					o_ram_wdata <= ret_r[15:8]; // high byte second
					o_ram_we    <= 1'b1;
					// unconditional page-local target
					o_pc    <= {ret_r[15:11], op_r[7:5], b2_r};
					state_r <= ST_WAIT; // psw not written
				end
				ST_WAIT:
				begin
					if (states_r >= need_r)
					begin
						o_code_addr  <= o_pc;
						o_instr_done <= 1'b1;
						state_r      <= ST_FETCH;
					end
				end
				default:
					state_r <= ST_FETCH;
				endcase
			end
		end
	end
endmodule // cies_exec
`default_nettype wire

/* File: verif/cies_mem.sv */
/* program memory and stack ram model; reads answer at once */
`timescale 1ns/1ps
`default_nettype none
module cies_mem(input wire logic i_clk, o_ram_we, input wire logic [15:0] o_code_addr,
	input wire logic [7:0] o_ram_addr, o_ram_wdata, output logic [7:0] i_code_data, i_ram_rdata);
logic [7:0] code [65536], ram [256];
// combinational reads, writes on the edge
assign i_code_data = code[o_code_addr];
assign i_ram_rdata = ram[o_ram_addr];
always @(posedge i_clk) if (o_ram_we) ram[o_ram_addr] <= o_ram_wdata;
endmodule // cies_mem
`default_nettype wire

/* File: verif/cies_exec_properties.sv */
/* port checker for cies_exec; one clock, sync reset */
`timescale 1ns/1ps
`default_nettype none
module cies_chk(input wire logic i_clk, i_srst, o_ram_we, o_illegal, o_instr_done,
	input wire logic [7:0] i_code_data, i_ram_rdata, i_psw_in, o_ram_addr, o_ram_wdata, o_sp, o_psw,
	input wire logic [15:0] o_code_addr, o_pc);
logic [15:0] p;
logic [7:0] s, op, b;
logic [1:0] n;
logic [5:0] c;
wire [15:0] r = p + 16'h2;
wire k = op[4:0] == 5'h11;
wire d = o_instr_done;
wire z = i_srst | d;
// state at instruction start, cycle and write counts
always @(posedge i_clk)
begin
	p <= z ? (i_srst ? 16'h0 : o_pc) : p;
	s <= z ? (i_srst ? 8'h07 : o_sp) : s;
	c <= z ? 6'h0 : c + 6'h1;
	n <= z ? 2'h0 : n + {1'b0, o_ram_we};
	if (o_code_addr == p) op <= i_code_data;
	if (o_code_addr == p + 16'h1) b <= i_code_data;
end
default clocking @(posedge i_clk); endclocking
default disable iff (i_srst);
a_call_sp: assert property (d && k |-> o_sp == s + 8'h2) else $error("sp");
a_push_addr: assert property (o_ram_we && k |-> o_ram_addr == s + 8'h1 + n)
	else $error("addr");
a_push_data: assert property (o_ram_we && k |-> o_ram_wdata == (n[0] ? r[15:8] : r[7:0]))
	else $error("data");
a_call_pc: assert property (d && k |-> o_pc == {r[15:11], op[7:5], b})
	else $error("target");
a_nop_pc: assert property (d && op == 8'h00 |-> o_pc == p + 16'h1 && o_sp == s)
	else $error("nop");
a_flags_kept: assert property (d |-> o_psw == $past(i_psw_in)) else $error("flags");
a_nop_time: assert property (d && op == 8'h00 |-> c > 6'h0a && c < 6'h0d)
	else $error("short");
a_long_time: assert property (d && (k || op == 8'hd5) |-> c > 6'h16 && c < 6'h19)
	else $error("long");
cover property (d && k);
cover property (d && op == 8'hd5);
cover property (d && o_illegal);
endmodule // cies_chk
bind cies_exec cies_chk u_chk(.*);
`default_nettype wire

/* File: verif/tb.sv */
/* random instruction stream checked against a model; uses cies_mem */
`timescale 1ns/1ps
`default_nettype none
module tb;
logic i_clk = 0, i_srst = 1;
logic [7:0] i_psw_in, op, b, dr, v;
logic [15:0] r = 16'h4270, m = 16'h0, rt;
int err_count = 0, tests_run = 0, sp = 7, ka, t, n, mr [256];
wire [15:0] o_code_addr, o_pc;
wire [7:0] i_code_data, i_ram_rdata, o_ram_addr, o_ram_wdata, o_sp, o_psw;
wire o_ram_we, o_illegal, o_instr_done;
always #2.5 i_clk = ~i_clk;
cies_exec u_dut(.*);
cies_mem u_mem(.*);
function logic [15:0] lf(input logic [15:0] x);
	return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
endfunction
task give_verdict;
	if (err_count == 0 && tests_run > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask
task ck(input string s, input logic [15:0] e, g);
	tests_run++;
	if (e !== g) begin err_count++; $display("MISMATCH %s exp %h got %h", s, e, g); end
endtask
// next random instruction at the model pc, new flags
task put;
	r = lf(r);
	b = r[15:8];
	dr = {6'h0c, r[6:5]};
	i_psw_in <= r[11:4];
	op = r[1:0] == 0 ? 8'h00 : r[1:0] == 1 ? 8'hd5 : r[1:0] == 2 ? {r[4:2], 5'h11} : 8'ha5;
	u_mem.code[m] = op;
	u_mem.code[m + 16'h1] = op == 8'hd5 ? dr : b;
	u_mem.code[m + 16'h2] = b;
endtask
initial
begin
	for (t = 0; t < 256; t++) begin mr[t] = t == 48 ? 1 : t; u_mem.ram[t] = 8'(mr[t]); end
	put;
	repeat (2) @(posedge i_clk);
	i_srst <= 1'b0;
	for (n = 0; n < 80; n++)
	begin
		@(negedge i_clk);
		for (t = 0; t < 80 && o_instr_done !== 1'b1; t++) @(negedge i_clk);
		if (t == 80) begin err_count++; give_verdict; end
		ka = sp - 1;
		if (op == 8'h00 || op == 8'ha5) m = m + 16'h1;
		else if (op == 8'hd5)
		begin
			v = 8'(mr[dr] - 1);
			mr[dr] = v;
			m = m + 16'h3;
			if (v != 8'h0) m = m + {{8{b[7]}}, b};
			ka = dr;
		end
		else
		begin
			rt = m + 16'h2;
			mr[sp + 1] = rt[7:0];
			mr[sp + 2] = rt[15:8];
			sp += 2;
			ka = sp - 1;
			m = {rt[15:11], op[7:5], b};
		end
		ck("pc", m, o_pc);
		ck("sp", 16'(sp), o_sp);
		ck("psw", i_psw_in, o_psw);
		ck("ram", 16'(mr[ka]), u_mem.ram[ka]);
		ck("ram", 16'(mr[ka + 1]), u_mem.ram[ka + 1]);
		if (op == 8'ha5) ck("illegal", 16'h1, o_illegal);
		@(posedge i_clk);
		put;
	end
	give_verdict;
end
endmodule // tb
`default_nettype wire
